/* File: hdl/ccsf_core.sv */
// Purpose: programmer-visible state, flags and address helpers of the core
// Assumes: vector bytes arrive from an outside memory port, one per cycle
// Notes: registers reachable over AXI4-Lite; operations launched by writes
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module ccsf_core
    import ccsf_pkg::*;
#(
    parameter int RAM_BANKS = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic boot_select_pin_high,
    input wire logic boot_select_pin_low,
    output logic [15:0] vec_addr,
    input wire logic [7:0] vec_data,
    output logic core_ready,
    output logic ext_access_en,
    output logic prog_mode
);
    logic [15:0] program_counter, accumulator, temporary_accumulator, stack_pointer;
    logic [15:0] processor_status_word, index_register, extra_pointer;
    ccsf_state_type state;
    logic [1:0] boot_meta, boot_sync, irq_level, area;
    logic [3:0] irq_level_req, irq_num, w_strb;
    logic [2:0] vec_call_num, gpr_num;
    logic [7:0] reset_mode, aw_addr, bank_select_pointer, condition_flags, next_flags;
    logic aw_held, w_held, do_write, irq_accept, op_go;
    logic [31:0] w_data;
    logic [15:0] gpr_addr, irq_vec_addr, call_vec_addr, next_acc;
    ccsf_op_type op_code;

    assign bank_select_pointer = processor_status_word[15:8];
    assign condition_flags = processor_status_word[7:0];
    assign irq_level = {condition_flags[FLAG_IL1], condition_flags[FLAG_IL0]};
    // level 0 field value compares no higher than any request, so nothing passes
    assign irq_accept = condition_flags[FLAG_I]
        && ({1'b0, irq_level_req[1:0]} < {1'b0, irq_level});
    // banks past the ram size wrap so no access leaves the register area
    assign gpr_addr = GPR_BASE + {8'h00,
        bank_select_pointer[4:0] & 5'(RAM_BANKS - 1), gpr_num};
    assign irq_vec_addr = VEC_IRQ0_HI - {11'h000, irq_num, 1'b0};
    assign call_vec_addr = VEC_CALL_BASE + {12'h000, vec_call_num, 1'b0};
    // io at the bottom, data above, program at the top of one 64K map
    assign area = (program_counter <= IO_TOP) ? 2'd0 :
        (program_counter <= DATA_TOP) ? 2'd1 : 2'd2;
    assign ext_access_en = (boot_sync != BOOT_SINGLE);
    assign prog_mode = (boot_sync == BOOT_PROG);
    assign core_ready = (state == ST_RUN);

    // boot pins come from outside, two flops before use
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            boot_meta <= 2'b00;
            boot_sync <= 2'b00;
        end
        else
        begin
            boot_meta <= {boot_select_pin_high, boot_select_pin_low};
            boot_sync <= boot_meta;
        end
    end

    // write channel capture, either order
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr <= OFF_RSTVEC && aw_addr[1:0] == 2'b00
                    && aw_addr != OFF_STAT && aw_addr != OFF_GADDR
                    && aw_addr != OFF_RSTVEC) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic [15:0] put16(input logic [15:0] old,
        input logic [31:0] d, input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0])
            r[7:0] = d[7:0];
        if (s[1])
            r[15:8] = d[15:8];
        return r;
    endfunction : put16
    assign op_go = do_write && aw_addr == OFF_OP && w_strb[0];
    assign op_code = ccsf_op_type'(w_data[3:0]);
    // result and flags; 8-bit forms use low bytes only
    always_comb
    begin
        logic [8:0] s8;
        logic [4:0] s4;
        logic [16:0] s16;
        logic [7:0] a8;
        logic [7:0] t8;
        logic [7:0] r8;
        logic upd;
        a8 = accumulator[7:0];
        t8 = temporary_accumulator[7:0];
        s8 = 9'h000;
        s4 = 5'h00;
        s16 = 17'h00000;
        r8 = 8'h00;
        upd = 1'b1;
        next_acc = accumulator;
        next_flags = condition_flags;
        case (op_code)
            OP_ADD:
            begin
                s8 = {1'b0, a8} + {1'b0, t8};
                s4 = {1'b0, a8[3:0]} + {1'b0, t8[3:0]};
                r8 = s8[7:0];
                next_flags[FLAG_V] = (a8[7] == t8[7]) && (r8[7] != a8[7]);
            end
            OP_SUB:
            begin
                s8 = {1'b0, t8} - {1'b0, a8};
                s4 = {1'b0, t8[3:0]} - {1'b0, a8[3:0]};
                r8 = s8[7:0];
                next_flags[FLAG_V] = (t8[7] != a8[7]) && (r8[7] != t8[7]);
            end
            OP_AND: r8 = a8 & t8;
            OP_OR: r8 = a8 | t8;
            OP_XOR: r8 = a8 ^ t8;
            OP_SHL:
            begin
                r8 = {a8[6:0], 1'b0};
                s8 = {a8[7], 8'h00};
            end
            OP_SHR:
            begin
                r8 = {1'b0, a8[7:1]};
                s8 = {a8[0], 8'h00};
            end
            OP_ADDW, OP_SUBW:
            begin
                s16 = (op_code == OP_ADDW) ? {1'b0, accumulator} + {1'b0, temporary_accumulator}
                    : {1'b0, temporary_accumulator} - {1'b0, accumulator};
                upd = 1'b0;
            end
            default: upd = 1'b0;
        endcase
        if (upd)
        begin
            next_acc = {accumulator[15:8], r8};
            next_flags[FLAG_N] = r8[7];
            next_flags[FLAG_Z] = (r8 == 8'h00);
            next_flags[FLAG_C] = s8[8];
            next_flags[FLAG_H] = s4[4];
        end
        if (op_code == OP_ADDW || op_code == OP_SUBW)
        begin
            next_acc = s16[15:0];
            next_flags[FLAG_N] = s16[15];
            next_flags[FLAG_Z] = (s16[15:0] == 16'h0000);
            next_flags[FLAG_C] = s16[16];
        end
        if (op_code == OP_SWAP)
            next_acc = temporary_accumulator;
    end
    // reset vector fetch, upper byte from the lower address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= ST_BOOT_HI;
            vec_addr <= VEC_RESET_HI;
            reset_mode <= 8'h00;
        end
        else
        begin
            case (state)
                ST_BOOT_HI:
                begin
                    state <= ST_BOOT_LO;
                    vec_addr <= VEC_RESET_HI + 16'h0001;
                end
                ST_BOOT_LO:
                begin
                    state <= ST_RUN;
                    vec_addr <= VEC_RESET_MODE;
                end
                ST_RUN:
                    if (vec_addr == VEC_RESET_MODE)
                    begin
                        reset_mode <= vec_data;
                        vec_addr <= VEC_TABLE_BASE;
                    end
                default: state <= ST_BOOT_HI;
            endcase
        end
    end
    // the dedicated registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            program_counter <= REG_RESET;
            accumulator <= REG_RESET;
            temporary_accumulator <= REG_RESET;
            stack_pointer <= REG_RESET;
            processor_status_word <= PSW_RESET;
            index_register <= REG_RESET;
            extra_pointer <= REG_RESET;
            irq_level_req <= 4'h0;
            irq_num <= 4'h0;
            vec_call_num <= 3'h0;
            gpr_num <= 3'h0;
        end
        else
        begin
            if (state == ST_BOOT_HI)
                program_counter[15:8] <= vec_data;
            else if (state == ST_BOOT_LO)
                program_counter[7:0] <= vec_data;
            else if (do_write && aw_addr == OFF_PC)
                program_counter <= put16(program_counter, w_data, w_strb);
            if (op_go)
            begin
                accumulator <= next_acc;
                processor_status_word[7:0] <= next_flags;
                if (op_code == OP_SWAP)
                    temporary_accumulator <= accumulator;
            end
            else
            begin
                if (do_write && aw_addr == OFF_ACC)
                    accumulator <= put16(accumulator, w_data, w_strb);
                if (do_write && aw_addr == OFF_TMP)
                    temporary_accumulator <= put16(temporary_accumulator, w_data, w_strb);
                if (do_write && aw_addr == OFF_PSW)
                    processor_status_word <= put16(processor_status_word, w_data, w_strb);
            end
            if (do_write && aw_addr == OFF_SP)
                stack_pointer <= put16(stack_pointer, w_data, w_strb);
            if (do_write && aw_addr == OFF_IDX)
                index_register <= put16(index_register, w_data, w_strb);
            if (do_write && aw_addr == OFF_EXT)
                extra_pointer <= put16(extra_pointer, w_data, w_strb);
            if (do_write && aw_addr == OFF_IRQ && w_strb[0])
            begin
                irq_level_req <= {2'b00, w_data[1:0]};
                irq_num <= (w_data[7:4] > IRQ_LAST) ? IRQ_LAST : w_data[7:4];
            end
            if (do_write && aw_addr == OFF_VEC && w_strb[0])
            begin
                gpr_num <= w_data[2:0];
                vec_call_num <= w_data[6:4];
            end
        end
    end

    // read channel, one cycle after address
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr[7:0])
                OFF_PC: s_axi_rdata <= {16'h0000, program_counter};
                OFF_ACC: s_axi_rdata <= {16'h0000, accumulator};
                OFF_TMP: s_axi_rdata <= {16'h0000, temporary_accumulator};
                OFF_SP: s_axi_rdata <= {16'h0000, stack_pointer};
                OFF_PSW: s_axi_rdata <= {16'h0000, processor_status_word};
                OFF_IDX: s_axi_rdata <= {16'h0000, index_register};
                OFF_EXT: s_axi_rdata <= {16'h0000, extra_pointer};
                OFF_OP: s_axi_rdata <= 32'h0000_0000;
                OFF_STAT: s_axi_rdata <= {18'h00000, area, reset_mode, core_ready,
                    prog_mode, ext_access_en, irq_accept};
                OFF_IRQ: s_axi_rdata <= {24'h000000, irq_num, 2'b00, irq_level_req[1:0]};
                OFF_GADDR: s_axi_rdata <= {16'h0000, gpr_addr};
                OFF_VEC: s_axi_rdata <= {call_vec_addr, irq_vec_addr};
                // stack image of pc: upper byte in the lower address lane
                OFF_RSTVEC: s_axi_rdata <= {16'h0000, program_counter[7:0],
                    program_counter[15:8]};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule : ccsf_core

/* File: pkg/ccsf_pkg.sv */
// Purpose: constants for the cpu core state and flags block
// Assumes: 8-bit core, 64K byte map, AXI4-Lite register access
// Notes: register offsets are byte addresses on a 32-bit bus
package ccsf_pkg;
    localparam logic [15:0] GPR_BASE = 16'h0100;
    localparam logic [15:0] GPR_LAST = 16'h017f;
    localparam logic [15:0] VEC_TABLE_BASE = 16'hffd0;
    localparam logic [15:0] VEC_CALL_BASE = 16'hffc0;
    localparam logic [15:0] VEC_RESET_HI = 16'hfffe;
    localparam logic [15:0] VEC_RESET_MODE = 16'hfffd;
    localparam logic [15:0] VEC_IRQ0_HI = 16'hfffa;
    localparam logic [15:0] IO_TOP = 16'h007f;
    localparam logic [15:0] DATA_TOP = 16'h7fff;
    localparam logic [3:0] IRQ_LAST = 4'hb;
    // register byte offsets
    localparam logic [7:0] OFF_PC = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_TMP = 8'h08;
    localparam logic [7:0] OFF_SP = 8'h0c;
    localparam logic [7:0] OFF_PSW = 8'h10;
    localparam logic [7:0] OFF_IDX = 8'h14;
    localparam logic [7:0] OFF_EXT = 8'h18;
    localparam logic [7:0] OFF_OP = 8'h1c;
    localparam logic [7:0] OFF_STAT = 8'h20;
    localparam logic [7:0] OFF_IRQ = 8'h24;
    localparam logic [7:0] OFF_GADDR = 8'h28;
    localparam logic [7:0] OFF_VEC = 8'h2c;
    localparam logic [7:0] OFF_RSTVEC = 8'h30;
    // condition flag bit positions
    localparam int FLAG_H = 7;
    localparam int FLAG_I = 6;
    localparam int FLAG_IL1 = 5;
    localparam int FLAG_IL0 = 4;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;
    localparam logic [15:0] PSW_RESET = 16'h0030;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [1:0] BOOT_SINGLE = 2'b00;
    localparam logic [1:0] BOOT_PROG = 2'b11;
    typedef enum logic [3:0]
    {
        OP_NONE = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_AND = 4'h3,
        OP_OR = 4'h4, OP_XOR = 4'h5, OP_SHL = 4'h6, OP_SHR = 4'h7,
        OP_ADDW = 4'h8, OP_SUBW = 4'h9, OP_SWAP = 4'ha
    } ccsf_op_type;
    typedef enum logic [2:0]
    {
        ST_BOOT_HI = 3'b001,
        ST_BOOT_LO = 3'b010,
        ST_RUN = 3'b100
    } ccsf_state_type;
endpackage : ccsf_pkg

/* File: bench/ccsf_core_sva.sv */
// Purpose: port-level checker for ccsf_core
// Assumes: one clock, synchronous active-low reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ns
module ccsf_core_sva
    import ccsf_pkg::*;
#(
    parameter int RAM_BANKS = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic boot_select_pin_high,
    input wire logic boot_select_pin_low,
    input wire logic [15:0] vec_addr,
    input wire logic [7:0] vec_data,
    input wire logic core_ready,
    input wire logic ext_access_en,
    input wire logic prog_mode
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // written without the reset guard: it speaks of the reset itself
    reset_vector_a: assert property (disable iff (1'b0)
        !aresetn |=> vec_addr == VEC_RESET_HI) else $error("vector address not parked");
    boot_fetch_a: assert property ($rose(aresetn) |-> vec_addr == VEC_RESET_HI
        ##1 vec_addr == 16'hffff && !core_ready
        ##1 vec_addr == VEC_RESET_MODE && core_ready) else $error("boot fetch order wrong");
    ready_keep_a: assert property (core_ready |=> core_ready)
        else $error("core ready dropped");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    ro_write_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && s_axi_awaddr[7:0] == OFF_STAT |-> ##2 s_axi_bresp == RESP_SLVERR)
        else $error("read-only write not refused");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response not held");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data not held");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    boot_single_a: assert property ((!boot_select_pin_high && !boot_select_pin_low)[*4]
        |-> !ext_access_en && !prog_mode) else $error("single chip mode wrong");
    boot_prog_a: assert property ((boot_select_pin_high && boot_select_pin_low)[*4]
        |-> ext_access_en && prog_mode) else $error("programming mode wrong");

    slverr_c: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
    rd_stall_c: cover property (s_axi_rvalid && !s_axi_rready);
    prog_c: cover property (prog_mode);
endmodule : ccsf_core_sva

bind ccsf_core ccsf_core_sva #(.RAM_BANKS(RAM_BANKS)) u_ccsf_core_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .boot_select_pin_high(boot_select_pin_high), .boot_select_pin_low(boot_select_pin_low),
    .vec_addr(vec_addr), .vec_data(vec_data), .core_ready(core_ready),
    .ext_access_en(ext_access_en), .prog_mode(prog_mode));

/* File: bench/cpu_core_state_and_flags_test.sv */
// Purpose: self-checking bench for ccsf_core over AXI4-Lite
// Assumes: vector memory modelled as a small combinational table
// Notes: operation rows first, then reset and corner cases
`timescale 1ns/1ns
module cpu_core_state_and_flags_test
    import ccsf_pkg::*;
;
    typedef struct packed
    {
        logic [15:0] a, t;
        ccsf_op_type op;
        logic [15:0] m, r;
        logic [7:0] fm, fv;
    } ccsf_row_type;
    logic aclk, aresetn;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic pin_h, pin_l, core_ready, ext_access_en, prog_mode, slow;
    logic [15:0] vec_addr;
    logic [7:0] vec_data;
    int errors, checks;
    logic [7:0] wide [3] = '{OFF_SP, OFF_IDX, OFF_EXT};
    logic [10:0] irq_rows [5] = '{{8'h60, 2'b01, 1'b1}, {8'h60, 2'b10, 1'b0},
        {8'h70, 2'b10, 1'b1}, {8'h70, 2'b11, 1'b0}, {8'h30, 2'b00, 1'b0}};
    ccsf_row_type rows [13] = '{
        '{16'h0008, 16'h0008, OP_ADD, 16'h00ff, 16'h0010, 8'h8f, 8'h80},
        '{16'h007f, 16'h0001, OP_ADD, 16'h00ff, 16'h0080, 8'h8f, 8'h8a},
        '{16'h0001, 16'h00ff, OP_ADD, 16'h00ff, 16'h0000, 8'h8f, 8'h85},
        '{16'h0001, 16'h0000, OP_SUB, 16'h00ff, 16'h00ff, 8'h8f, 8'h89},
        '{16'h0001, 16'h0080, OP_SUB, 16'h00ff, 16'h007f, 8'h8f, 8'h82},
        '{16'h00f0, 16'h000f, OP_AND, 16'h00ff, 16'h0000, 8'h0c, 8'h04},
        '{16'h0080, 16'h0001, OP_OR, 16'h00ff, 16'h0081, 8'h0c, 8'h08},
        '{16'h0055, 16'h0055, OP_XOR, 16'h00ff, 16'h0000, 8'h0c, 8'h04},
        '{16'h0081, 16'h0000, OP_SHL, 16'h00ff, 16'h0002, 8'h8d, 8'h01},
        '{16'h0001, 16'h0000, OP_SHR, 16'h00ff, 16'h0000, 8'h8d, 8'h05},
        '{16'h00ff, 16'h0001, OP_ADDW, 16'hffff, 16'h0100, 8'h0c, 8'h00},
        '{16'h0002, 16'h0001, OP_SUBW, 16'hffff, 16'hffff, 8'h0c, 8'h08},
        '{16'h1234, 16'habcd, OP_SWAP, 16'hffff, 16'habcd, 8'h00, 8'h00}};

    // start address 1234, mode byte 5a everywhere else
    assign vec_data = vec_addr == 16'hfffe ? 8'h12 : vec_addr == 16'hffff ? 8'h34 : 8'h5a;

    ccsf_core #(.RAM_BANKS(16)) u_ccsf_core (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .boot_select_pin_high(pin_h), .boot_select_pin_low(pin_l), .vec_addr(vec_addr),
        .vec_data(vec_data), .core_ready(core_ready), .ext_access_en(ext_access_en),
        .prog_mode(prog_mode));

    always #2 aclk = ~aclk;

    task automatic print_verdict;
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic hang(input int n);
        if (n >= 50)
        begin
            errors++;
            print_verdict();
        end
    endtask : hang

    // slow holds the ready back until the answer has stood a cycle
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        int n;
        bit a;
        bit w;
        n = 0;
        a = 0;
        w = 0;
        s_axi_awaddr <= {24'h0, ad};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !slow;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
            begin
                a = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready)
            begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(a && w) && n < 50);
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_bvalid)
                s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
        hang(n);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // an idle edge keeps the next call from driving ready twice
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] ad);
        int n;
        n = 0;
        s_axi_araddr <= {24'h0, ad};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !slow;
        do
        begin
            @(posedge aclk);
            n++;
        end while (!s_axi_arready && n < 50);
        s_axi_arvalid <= 1'b0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_rvalid)
                s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
        hang(n);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic do_reset;
        int n;
        n = 0;
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
        end while (!core_ready && n < 50);
        hang(n);
    endtask : do_reset

    initial
    begin
        aclk = 0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        {pin_h, pin_l, slow} = '0;
        errors = 0;
        checks = 0;
        do_reset();
        foreach (rows[i])
        begin
            wr(OFF_ACC, {16'h0, rows[i].a});
            wr(OFF_TMP, {16'h0, rows[i].t});
            wr(OFF_OP, {28'h0, rows[i].op});
            rd(OFF_ACC);
            check("result", rdat & rows[i].m, {16'h0, rows[i].r});
            rd(OFF_PSW);
            check("flags", rdat & rows[i].fm, {24'h0, rows[i].fv});
        end
        // bank 15 is the last one below the wrap
        wr(OFF_PSW, 32'h0f30);
        rd(OFF_PSW);
        check("status", rdat, 32'h0f30);
        wr(OFF_VEC, 32'h23);
        wr(OFF_IRQ, 32'hf0);
        rd(OFF_GADDR);
        check("reg_addr", rdat, 32'h017b);
        rd(OFF_VEC);
        check("vectors", rdat, 32'hffc4ffe4);
        wr(OFF_IRQ, 32'h00);
        rd(OFF_VEC);
        check("vectors", rdat, 32'hffc4fffa);
        foreach (irq_rows[i])
        begin
            wr(OFF_PSW, {24'h0, irq_rows[i][10:3]});
            wr(OFF_IRQ, {24'h0, 4'hb, 2'b00, irq_rows[i][2:1]});
            rd(OFF_STAT);
            check("irq_accept", {31'h0, rdat[0]}, {31'h0, irq_rows[i][0]});
        end
        wr(OFF_ACC, 32'hffff);
        s_axi_wstrb <= 4'h1;
        wr(OFF_ACC, 32'h00aa);
        s_axi_wstrb <= 4'hf;
        rd(OFF_ACC);
        check("low_byte", rdat, 32'hffaa);
        foreach (wide[i])
        begin
            wr(wide[i], 32'h1a5c3);
            rd(wide[i]);
            check("wide_reg", rdat, 32'ha5c3);
        end
        wr(OFF_PC, 32'hff00);
        rd(OFF_STAT);
        check("area", rdat & 32'h3000, 32'h2000);
        slow = 1;
        wr(OFF_STAT, 32'hffff);
        check("ro_resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        rd(8'h40);
        check("unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
        rd(OFF_OP);
        check("op_read", rdat, 32'h0);
        slow = 0;
        {pin_h, pin_l} <= 2'b11;
        repeat (4) @(posedge aclk);
        rd(OFF_STAT);
        check("prog_pins", rdat & 32'h6, 32'h6);
        {pin_h, pin_l} <= 2'b01;
        repeat (4) @(posedge aclk);
        rd(OFF_STAT);
        check("ext_pins", rdat & 32'h6, 32'h2);
        {pin_h, pin_l} <= 2'b00;
        do_reset();
        rd(OFF_PSW);
        check("psw_reset", rdat, 32'h0030);
        rd(OFF_PC);
        check("start_addr", rdat, 32'h1234);
        rd(OFF_RSTVEC);
        check("pc_image", rdat, 32'h3412);
        rd(OFF_ACC);
        check("acc_reset", rdat, 32'h0);
        rd(OFF_STAT);
        check("stat_reset", rdat, 32'h15a8);
        print_verdict();
    end
endmodule : cpu_core_state_and_flags_test
